// >>> design/decoder_defs.svh
`ifndef DECODER_DEFS_SVH
`define DECODER_DEFS_SVH
// Overview of operation
// - F6/F7 field 111: signed divide, 44-52/53-61
// - D4 0A: decimal adjust multiply, 19 clocks
// - D5 0A: decimal adjust divide, 15 clocks
// - 98: byte to word extend, 2 clocks
// - 99: word to dword extend, 4 clocks
// - AND 001000dw, OR 000010dw: 3/10 clocks
// - 1000010w test, flags only, 3/10 clocks
// - F6/F7 field 000 immediate test: 4/10
// - 1010100w accumulator immediate test: 3/4 clocks
// - Word memory operand adds 4 clocks, except for signed divide

// ****************************************************************
// Opcode patterns (mask, match)
// ****************************************************************
`define OPC_GRP3_MASK      8'hfe
`define OPC_GRP3           8'hf6
`define OPC_AND_RM_MASK    8'hfc
`define OPC_AND_RM         8'h20
`define OPC_OR_RM          8'h08
`define OPC_TEST_RM_MASK   8'hfe
`define OPC_TEST_RM        8'h84
`define OPC_TEST_ACC       8'ha8
`define OPC_ADJ_MUL        8'hd4
`define OPC_ADJ_DIV        8'hd5
`define OPC_ADJ_BASE       8'h0a
`define OPC_BYTE_EXT       8'h98
`define OPC_WORD_EXT       8'h99

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_W              0
`define BIT_D              1
`define MOD_HI             7
`define MOD_LO             6
`define FLD_HI             5
`define FLD_LO             3
`define MOD_REG            2'h3
`define FLD_TEST           3'h0
`define FLD_SDIV           3'h7

// ****************************************************************
// Clock counts
// ****************************************************************
`define CLK_SDIV_RB        7'h2c
`define CLK_SDIV_RB_MAX    7'h34
`define CLK_SDIV_RW        7'h35
`define CLK_SDIV_RW_MAX    7'h3d
`define CLK_ADJ_MUL        7'h13
`define CLK_ADJ_DIV        7'h0f
`define CLK_BYTE_EXT       7'h02
`define CLK_WORD_EXT       7'h04
`define CLK_LOGIC_REG      7'h03
`define CLK_LOGIC_MEM      7'h0a
`define CLK_TEST_IMM_REG   7'h04
`define CLK_TEST_IMM_MEM   7'h0a
`define CLK_ACC_BYTE       7'h03
`define CLK_ACC_WORD       7'h04
`define CLK_WORD_MEM_ADD   7'h04
`define CLK_ONE            7'h01
`endif

// >>> design/decoder_pkg.sv
package decoder_pkg;
    typedef enum logic [3:0] {
        OP_NONE, OP_SIGNED_DIVIDE, OP_DECIMAL_ADJUST_MULTIPLY, OP_DECIMAL_ADJUST_DIVIDE,
        OP_BYTE_TO_WORD_EXTEND, OP_WORD_TO_DWORD_EXTEND, OP_AND, OP_OR, OP_TEST_RM,
        OP_TEST_IMM_RM, OP_TEST_IMM_ACC
    } op_kind_t;

    typedef struct packed {
        op_kind_t   kind;
        logic       word;       // Operand width: 1 word, 0 byte
        logic       reg_dest;   // Register field is destination
        logic       mem;        // Memory operand present
        logic       writes;     // Result written back
        logic [1:0] imm_bytes;  // Immediate bytes that follow
        logic [6:0] clocks;     // Base clock count
        logic [6:0] clocks_max; // Upper clock count
    } decode_t;
endpackage

// >>> design/opcode_classify.sv
`timescale 1ns/1ns
`include "decoder_defs.svh"
module opcode_classify (
    // Instruction bytes
    input  wire logic [7:0]         op_i,
    input  wire logic [7:0]         modrm_i,
    // Classification
    output decoder_pkg::decode_t    dec_o,
    output logic                    need_second_o,
    output logic                    valid_o
);
    logic                   w;
    logic                   memop;
    logic [2:0]             fld;

    // Memory-operand count, with word surcharge
    function automatic logic [6:0] mem_clk(input logic [6:0] base, input logic wd);
        mem_clk = wd ? base + `CLK_WORD_MEM_ADD : base;
    endfunction

    assign w     = op_i[`BIT_W];
    assign memop = modrm_i[`MOD_HI:`MOD_LO] != `MOD_REG;
    assign fld   = modrm_i[`FLD_HI:`FLD_LO];

    // Decode one opcode with its addressing byte
    always_comb begin
        dec_o          = '0;
        dec_o.kind     = decoder_pkg::OP_NONE;
        dec_o.word     = w;
        dec_o.reg_dest = op_i[`BIT_D];
        need_second_o  = 1'b0;
        valid_o        = 1'b1;
        if ((op_i & `OPC_GRP3_MASK) == `OPC_GRP3) begin
            need_second_o = 1'b1;
            dec_o.mem     = memop;
            if (fld == `FLD_SDIV) begin
                dec_o.kind       = decoder_pkg::OP_SIGNED_DIVIDE;
                dec_o.writes     = 1'b1;
                dec_o.clocks     = w ? `CLK_SDIV_RW : `CLK_SDIV_RB;
                dec_o.clocks_max = w ? `CLK_SDIV_RW_MAX : `CLK_SDIV_RB_MAX;
            end else if (fld == `FLD_TEST) begin
                dec_o.kind       = decoder_pkg::OP_TEST_IMM_RM;
                dec_o.imm_bytes  = w ? 2'h2 : 2'h1;
                dec_o.clocks     = memop ? mem_clk(`CLK_TEST_IMM_MEM, w) : `CLK_TEST_IMM_REG;
                dec_o.clocks_max = dec_o.clocks;
            end else begin
                valid_o = 1'b0;
            end
        end else if ((op_i & `OPC_AND_RM_MASK) == `OPC_AND_RM ||
                     (op_i & `OPC_AND_RM_MASK) == `OPC_OR_RM) begin
            need_second_o    = 1'b1;
            dec_o.kind       = ((op_i & `OPC_AND_RM_MASK) == `OPC_AND_RM) ?
                               decoder_pkg::OP_AND : decoder_pkg::OP_OR;
            dec_o.mem        = memop;
            dec_o.writes     = 1'b1;
            dec_o.clocks     = memop ? mem_clk(`CLK_LOGIC_MEM, w) : `CLK_LOGIC_REG;
            dec_o.clocks_max = dec_o.clocks;
        end else if ((op_i & `OPC_TEST_RM_MASK) == `OPC_TEST_RM) begin
            need_second_o    = 1'b1;
            dec_o.kind       = decoder_pkg::OP_TEST_RM;
            dec_o.mem        = memop;
            dec_o.clocks     = memop ? mem_clk(`CLK_LOGIC_MEM, w) : `CLK_LOGIC_REG;
            dec_o.clocks_max = dec_o.clocks;
        end else if ((op_i & `OPC_TEST_RM_MASK) == `OPC_TEST_ACC) begin
            dec_o.kind       = decoder_pkg::OP_TEST_IMM_ACC;
            dec_o.imm_bytes  = w ? 2'h2 : 2'h1;
            dec_o.clocks     = w ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
            dec_o.clocks_max = dec_o.clocks;
        end else if (op_i == `OPC_ADJ_MUL || op_i == `OPC_ADJ_DIV) begin
            need_second_o    = 1'b1;
            valid_o          = modrm_i == `OPC_ADJ_BASE;
            dec_o.kind       = (op_i == `OPC_ADJ_MUL) ? decoder_pkg::OP_DECIMAL_ADJUST_MULTIPLY
                                                      : decoder_pkg::OP_DECIMAL_ADJUST_DIVIDE;
            dec_o.writes     = 1'b1;
            dec_o.clocks     = (op_i == `OPC_ADJ_MUL) ? `CLK_ADJ_MUL : `CLK_ADJ_DIV;
            dec_o.clocks_max = dec_o.clocks;
        end else if (op_i == `OPC_BYTE_EXT) begin
            dec_o.kind       = decoder_pkg::OP_BYTE_TO_WORD_EXTEND;
            dec_o.writes     = 1'b1;
            dec_o.clocks     = `CLK_BYTE_EXT;
            dec_o.clocks_max = dec_o.clocks;
        end else if (op_i == `OPC_WORD_EXT) begin
            dec_o.kind       = decoder_pkg::OP_WORD_TO_DWORD_EXTEND;
            dec_o.writes     = 1'b1;
            dec_o.clocks     = `CLK_WORD_EXT;
            dec_o.clocks_max = dec_o.clocks;
        end else begin
            valid_o = 1'b0;
        end
    end
endmodule

// >>> design/cycle_timer.sv
`timescale 1ns/1ns
`include "decoder_defs.svh"
module cycle_timer (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       load_i,
    input  wire logic [6:0] count_i,
    // Status
    output logic            busy_o,
    output logic            last_o
);
    typedef struct packed {
        logic [6:0] remain;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    // Count down the clocks of one operation
    always_comb begin
        state_next = state_reg;
        if (load_i) begin
            state_next.remain = count_i;
        end else if (state_reg.remain != 7'h00) begin
            state_next.remain = state_reg.remain - `CLK_ONE;
        end
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy_o = state_reg.remain != 7'h00;
    assign last_o = state_reg.remain == `CLK_ONE;
endmodule

// >>> design/divide_adjust_logic_op_decoder.sv
`timescale 1ns/1ns
`include "decoder_defs.svh"
module divide_adjust_logic_op_decoder (
    // Clock and reset
    input  wire logic                   clock_i,
    input  wire logic                   rst_n_i,
    // Prefetch queue side
    input  wire logic                   byte_valid_i,
    input  wire logic [7:0]             byte_i,
    output logic                        byte_ready_o,
    // Execution side
    output decoder_pkg::decode_t        dec_o,
    output logic [15:0]                 imm_o,
    output logic [7:0]                  modrm_o,
    output logic                        issue_o,
    output logic                        exec_busy_o,
    output logic                        exec_done_o,
    output logic                        illegal_o
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {ST_OPCODE, ST_SECOND, ST_IMM_LO, ST_IMM_HI, ST_EXEC} fsm_t;

    typedef struct packed {
        fsm_t                   fsm;
        logic [7:0]             op;
        logic [7:0]             modrm;
        logic [15:0]            imm;
        decoder_pkg::decode_t   dec;
        logic                   issue;
        logic                   done;
        logic                   illegal;
        logic                   ready;
        logic                   busy;
    } core_state_t;

    core_state_t state_reg;
    core_state_t state_next;

    decoder_pkg::decode_t   cls_dec;
    logic                   cls_need_second;
    logic                   cls_valid;
    logic                   tmr_last;
    logic                   tmr_load;
    logic [7:0]             cls_op;
    logic [7:0]             cls_second;
    logic                   take;

    assign take       = byte_valid_i && state_reg.ready;
    assign cls_op     = (state_reg.fsm == ST_OPCODE) ? byte_i : state_reg.op;
    assign cls_second = (state_reg.fsm == ST_SECOND) ? byte_i : 8'h00;

    // ****************************************************************
    // Opcode classifier and clock counter
    // ****************************************************************
    opcode_classify u_classify (
        .op_i          (cls_op),
        .modrm_i       (cls_second),
        .dec_o         (cls_dec),
        .need_second_o (cls_need_second),
        .valid_o       (cls_valid)
    );

    cycle_timer u_timer (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .load_i  (tmr_load),
        .count_i (state_next.dec.clocks),
        .busy_o  (),
        .last_o  (tmr_last)
    );

    // Start counting when the instruction is fully fetched
    assign tmr_load = state_next.issue;

    // Fetch bytes, decode, and hold for the execution clocks
    always_comb begin
        state_next         = state_reg;
        state_next.issue   = 1'b0;
        state_next.done    = 1'b0;
        state_next.illegal = 1'b0;
        case (state_reg.fsm)
            ST_OPCODE: begin
                if (take) begin
                    state_next.op  = byte_i;
                    state_next.imm = '0;
                    if (cls_need_second) begin
                        state_next.fsm = ST_SECOND;
                    end else if (!cls_valid) begin
                        state_next.illegal = 1'b1;
                    end else begin
                        state_next.dec = cls_dec;
                        state_next.fsm = (cls_dec.imm_bytes != 2'h0) ? ST_IMM_LO : ST_EXEC;
                    end
                end
            end
            ST_SECOND: begin
                if (take) begin
                    state_next.modrm = byte_i;
                    state_next.dec   = cls_dec;
                    if (!cls_valid) begin
                        state_next.illegal = 1'b1;
                        state_next.fsm     = ST_OPCODE;
                    end else begin
                        state_next.fsm = (cls_dec.imm_bytes != 2'h0) ? ST_IMM_LO : ST_EXEC;
                    end
                end
            end
            ST_IMM_LO: begin
                if (take) begin
                    state_next.imm[7:0] = byte_i;
                    state_next.fsm = (state_reg.dec.imm_bytes == 2'h2) ? ST_IMM_HI : ST_EXEC;
                end
            end
            ST_IMM_HI: begin
                if (take) begin
                    state_next.imm[15:8] = byte_i;
                    state_next.fsm       = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (tmr_last) begin
                    state_next.done = 1'b1;
                    state_next.fsm  = ST_OPCODE;
                end
            end
            default: begin
                state_next.fsm = ST_OPCODE;
            end
        endcase
        state_next.issue = (state_reg.fsm != ST_EXEC) && (state_next.fsm == ST_EXEC);
        state_next.ready = state_next.fsm != ST_EXEC;
        state_next.busy  = state_next.fsm == ST_EXEC; // Registered so the busy output comes from a flop
    end

    // State register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg       <= '0;
            state_reg.fsm   <= ST_OPCODE;
            state_reg.ready <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Registered outputs
    assign byte_ready_o = state_reg.ready;
    assign dec_o        = state_reg.dec;
    assign imm_o        = state_reg.imm;
    assign modrm_o      = state_reg.modrm;
    assign issue_o      = state_reg.issue;
    assign exec_busy_o  = state_reg.busy;
    assign exec_done_o  = state_reg.done;
    assign illegal_o    = state_reg.illegal;
endmodule

// >>> tb/decoder_asserts.sv
`timescale 1ns/1ns
module decoder_asserts (
    // Clock and reset
    input wire logic                 clock_i,
    input wire logic                 rst_n_i,
    // Queue side
    input wire logic                 byte_valid_i,
    input wire logic [7:0]           byte_i,
    input wire logic                 byte_ready_o,
    // Execution side
    input wire decoder_pkg::decode_t dec_o,
    input wire logic [15:0]          imm_o,
    input wire logic [7:0]           modrm_o,
    input wire logic                 issue_o,
    input wire logic                 exec_busy_o,
    input wire logic                 exec_done_o,
    input wire logic                 illegal_o
);
    // ****
    // Helpers
    // ****
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [6:0] busy_cnt_reg;

    // Counts busy cycles from issue
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_cnt_reg <= 7'h00;
        end else if (issue_o) begin
            busy_cnt_reg <= 7'h01;
        end else if (exec_busy_o) begin
            busy_cnt_reg <= busy_cnt_reg + 7'h01;
        end
    end

    // ****
    // Assertions
    // ****
    a_divide_counts: assert property (issue_o && dec_o.kind == decoder_pkg::OP_SIGNED_DIVIDE
        |-> dec_o.clocks == (dec_o.word ? 7'h35 : 7'h2c) && dec_o.clocks_max == (dec_o.word ? 7'h3d : 7'h34))
        else $error("signed divide counts wrong");
    a_adjust_mul: assert property (issue_o && dec_o.kind == decoder_pkg::OP_DECIMAL_ADJUST_MULTIPLY
        |-> dec_o.clocks == 7'h13 && modrm_o == 8'h0a) else $error("adjust multiply wrong");
    a_adjust_div: assert property (issue_o && dec_o.kind == decoder_pkg::OP_DECIMAL_ADJUST_DIVIDE
        |-> dec_o.clocks == 7'h0f && modrm_o == 8'h0a) else $error("adjust divide wrong");
    a_extend_counts: assert property (issue_o && dec_o.kind inside {decoder_pkg::OP_BYTE_TO_WORD_EXTEND,
        decoder_pkg::OP_WORD_TO_DWORD_EXTEND}
        |-> dec_o.clocks == (dec_o.kind == decoder_pkg::OP_BYTE_TO_WORD_EXTEND ? 7'h02 : 7'h04))
        else $error("extend count wrong");
    a_logic_counts: assert property (issue_o && dec_o.kind inside {decoder_pkg::OP_AND, decoder_pkg::OP_OR}
        |-> dec_o.writes && dec_o.clocks == (dec_o.mem ? (dec_o.word ? 7'h0e : 7'h0a) : 7'h03))
        else $error("and or count wrong");
    a_test_rm: assert property (issue_o && dec_o.kind == decoder_pkg::OP_TEST_RM
        |-> !dec_o.writes && dec_o.clocks == (dec_o.mem ? (dec_o.word ? 7'h0e : 7'h0a) : 7'h03))
        else $error("test register count wrong");
    a_test_imm: assert property (issue_o && dec_o.kind == decoder_pkg::OP_TEST_IMM_RM
        |-> !dec_o.writes && dec_o.imm_bytes == (dec_o.word ? 2'h2 : 2'h1)
        && dec_o.clocks == (dec_o.mem ? (dec_o.word ? 7'h0e : 7'h0a) : 7'h04)) else $error("test immediate wrong");
    a_test_acc: assert property (issue_o && dec_o.kind == decoder_pkg::OP_TEST_IMM_ACC
        |-> dec_o.clocks == (dec_o.word ? 7'h04 : 7'h03)) else $error("accumulator test count wrong");
    a_busy_length: assert property (exec_done_o |-> busy_cnt_reg == dec_o.clocks
        && !exec_busy_o && $past(exec_busy_o)) else $error("execution length wrong");
    a_busy_refuse: assert property (exec_busy_o |-> !byte_ready_o ##1 (exec_busy_o || exec_done_o))
        else $error("byte taken while busy");
endmodule

bind divide_adjust_logic_op_decoder decoder_asserts i_decoder_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o), .dec_o(dec_o), .imm_o(imm_o),
    .modrm_o(modrm_o), .issue_o(issue_o), .exec_busy_o(exec_busy_o), .exec_done_o(exec_done_o),
    .illegal_o(illegal_o));

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
    // ****
    // Signals
    // ****
    logic                 clock_i;
    logic                 rst_n_i;
    logic                 byte_valid_i;
    logic [7:0]           byte_i;
    logic                 byte_ready_o;
    decoder_pkg::decode_t dec_o;
    logic [15:0]          imm_o;
    logic [7:0]           modrm_o;
    logic                 issue_o;
    logic                 exec_busy_o;
    logic                 exec_done_o;
    logic                 illegal_o;
    int                   n_mismatch;
    int                   n_compared;
    int                   cycles;

    divide_adjust_logic_op_decoder i_divide_adjust_logic_op_decoder (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i), .byte_ready_o(byte_ready_o), .dec_o(dec_o), .imm_o(imm_o),
        .modrm_o(modrm_o), .issue_o(issue_o), .exec_busy_o(exec_busy_o), .exec_done_o(exec_done_o),
        .illegal_o(illegal_o));

    // Clock of 50 ns
    always #25 clock_i = ~clock_i;

    // Cycle ceiling against hangs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ****
    // Shared tasks
    // ****
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    // Offers one byte until taken, returns a falling edge later
    task automatic put(input logic [7:0] b);
        byte_valid_i = 1'b1;
        byte_i = b;
        while (byte_ready_o !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
    endtask

    // Sends n bytes, low byte first, then times the execution
    task automatic go(input logic [31:0] b, input int n, input decoder_pkg::op_kind_t k, input logic [6:0] clk);
        int c;
        c = 0;
        for (int i = 0; i < n; i++) put(b[8*i+:8]);
        byte_valid_i = 1'b0;
        chk(issue_o === 1'b1 && dec_o.kind === k, "no issue or wrong kind");
        chk(dec_o.clocks === clk, "clock count");
        chk(illegal_o === 1'b0, "illegal on legal sequence");
        while (exec_busy_o === 1'b1) begin
            c++;
            @(negedge clock_i);
        end
        chk(exec_done_o === 1'b1 && c == int'(clk), "duration");
    endtask

    // Sends a refused sequence and expects the illegal pulse
    task automatic bad(input logic [15:0] b, input int n);
        for (int i = 0; i < n; i++) put(b[8*i+:8]);
        byte_valid_i = 1'b0;
        chk(illegal_o === 1'b1, "no illegal pulse");
        @(negedge clock_i);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_divide_adjust();
        go(32'hf8f6, 2, decoder_pkg::OP_SIGNED_DIVIDE, 7'h2c);
        chk(modrm_o === 8'hf8 && dec_o.mem === 1'b0 && dec_o.writes === 1'b1, "divide addressing byte");
        go(32'hf8f7, 2, decoder_pkg::OP_SIGNED_DIVIDE, 7'h35);
        go(32'h0ad4, 2, decoder_pkg::OP_DECIMAL_ADJUST_MULTIPLY, 7'h13);
        go(32'h0ad5, 2, decoder_pkg::OP_DECIMAL_ADJUST_DIVIDE, 7'h0f);
        go(32'h98, 1, decoder_pkg::OP_BYTE_TO_WORD_EXTEND, 7'h02);
        go(32'h99, 1, decoder_pkg::OP_WORD_TO_DWORD_EXTEND, 7'h04);
    endtask

    task automatic t_and_or();
        go(32'hc020, 2, decoder_pkg::OP_AND, 7'h03);
        chk(dec_o.word === 1'b0 && dec_o.reg_dest === 1'b0, "byte source fields");
        go(32'h0023, 2, decoder_pkg::OP_AND, 7'h0e);
        chk(dec_o.word === 1'b1 && dec_o.reg_dest === 1'b1 && dec_o.mem === 1'b1, "word dest fields");
        go(32'hc008, 2, decoder_pkg::OP_OR, 7'h03);
        go(32'h070a, 2, decoder_pkg::OP_OR, 7'h0a);
    endtask

    task automatic t_test();
        go(32'hc084, 2, decoder_pkg::OP_TEST_RM, 7'h03);
        go(32'h0785, 2, decoder_pkg::OP_TEST_RM, 7'h0e);
        chk(dec_o.writes === 1'b0, "test writes");
        go(32'h55c0f6, 3, decoder_pkg::OP_TEST_IMM_RM, 7'h04);
        chk(imm_o === 16'h0055 && dec_o.imm_bytes === 2'h1, "byte immediate");
        go(32'h123400f7, 4, decoder_pkg::OP_TEST_IMM_RM, 7'h0e);
        chk(imm_o === 16'h1234 && dec_o.imm_bytes === 2'h2, "word immediate");
        go(32'h12a8, 2, decoder_pkg::OP_TEST_IMM_ACC, 7'h03);
        go(32'h1234a9, 3, decoder_pkg::OP_TEST_IMM_ACC, 7'h04);
        chk(imm_o === 16'h1234 && dec_o.word === 1'b1, "accumulator immediate");
    endtask

    task automatic t_refused();
        bad(16'h0000, 1);
        bad(16'h0bd4, 2);
        bad(16'h0bd5, 2);
        bad(16'hd8f6, 2);
    endtask

    // Main sequence
    initial begin
        clock_i = 1'b0;
        rst_n_i = 1'b0;
        byte_valid_i = 1'b0;
        byte_i = 8'h00;
        n_mismatch = 0;
        n_compared = 0;
        cycles = 0;
        repeat (2) @(negedge clock_i);
        rst_n_i = 1'b1;
        chk(byte_ready_o === 1'b1 && exec_busy_o === 1'b0, "state after reset");
        t_divide_adjust();
        t_and_or();
        t_test();
        t_refused();
        end_of_test();
    end
endmodule
